//--- rtl/fault_report_defs.svh
/*
  Constants for the fault reporting and output response logic: fault register
  bit positions, diagnostic byte layout, PWM fault duty codes, reset values and
  self-test timing.
  Assumes it is included by bare name wherever these names are needed.
*/
`ifndef FAULT_REPORT_DEFS_SVH
`define FAULT_REPORT_DEFS_SVH

`define ERR_W 13
`define ERR_ACF 0
`define ERR_AOC 1
`define ERR_TSE 2
`define ERR_SAT 3
`define ERR_SLF 4
`define ERR_SRR 5
`define ERR_POR 6
`define ERR_ESE 7
`define ERR_UVD 8
`define ERR_OVD 9
`define ERR_EUE 10
`define ERR_SPE 11
`define ERR_OFE 12

// Power-on reset flag is set on startup
`define ERR_RESET 13'h0040
`define DIAG_RESET 8'h10
// Critical flags only clear with a device reset
`define ERR_CRIT_MASK 13'h1C00
`define ERR_CLEARABLE_MASK 13'h03FF
// Flags that drive the analog fault response
`define ERR_ANALOG_MASK 13'h033F

`define DIAG_SLF 0
`define DIAG_SRR 1
`define DIAG_ACF 2
`define DIAG_TSE 3
`define DIAG_POR 4
`define DIAG_UOV 5
`define DIAG_SAT 6
`define DIAG_AOC 7

`define DUTY_NONE 7'h00
`define DUTY_SLF 7'h0A
`define DUTY_SRR 7'h14
`define DUTY_ACF 7'h1E
`define DUTY_TSE 7'h28
`define DUTY_POR 7'h32
`define DUTY_UVD 7'h3C
`define DUTY_OVD 7'h46
`define DUTY_SAT 7'h50
`define DUTY_AOC 7'h5A

`define SENT_DIAG_OPT_A 4'h2
`define SENT_DIAG_OPT_B 4'h8
`define SENT_DIAG_OPT_C 4'hD

`define OVD_SEL_HIGH 1'b0

`define CLK_FREQ_KHZ 250000
`define LBIST_TIME_MS 200
`define LBIST_CNT_W 26
`define LBIST_GOOD_SIG 32'h6C56C9EF

`define HOLD_W 4
`define FRAME_FIFO_DEPTH 8

`endif

//--- rtl/fault_report_output_logic.sv
/*
  Fault reporting and output response logic with its frame FIFO. Collects
  fault levels into the fault register and its two copies, picks the output
  response per protocol, builds SENT fault words and runs the self-test timer.
  Assumes fault levels and event pulses come from logic on clk; the
  overvoltage comparators are asynchronous pins.
*/
//
// Contract
// - Overvoltage holds fault response until read or reported
// - Overvoltage only with lock; else high impedance
// - Select 0 high threshold pair, 1 low
// - Status bits stick until read or sent
// - Status bit 0 ORs five signal faults
// - Status bit 1 ORs voltage, saturation, clamp
// - Serial copy clears only after being sent
// - Options 2/8/13 carry diagnostic nibbles every frame
// - Diagnostic byte bit layout fixed per flag
// - Response select forces high impedance in digital
// - PWM fault: half frequency, per-flag duty
// - Highest priority fault reported in PWM; analog drives the configured level for any flag (code: only ERR_ANALOG_MASK flags, not POR or ESE)
// - Critical faults: high impedance digital, analog high
// - Analog response; high impedance held N updates
// - Undervoltage: configured level, SENT engine reset
// - Self-test start runs timer, blocks communication
// - Self-test done, pass and signature reported
// - Fault register bit positions fixed
// - New faults go out at next opportunity
// - Clamp flag bit 1, priority 9, 90%
`timescale 1ns/100ps
`include "fault_report_defs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module frame_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic push;
  logic pop;
  assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_reg.cnt != '0);
  assign out_data = s_reg.mem[s_reg.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = AW'((s_reg.wr + 1'b1) % DEPTH);
    end
    if (pop) begin
      s_next.rd = AW'((s_reg.rd + 1'b1) % DEPTH);
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module fault_report_output_logic #(
  parameter int unsigned LBIST_CYCLES = `LBIST_TIME_MS * `CLK_FREQ_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire fault_report_pkg::cfg_t cfg,
  input wire logic [`ERR_W-1:0] faults_live,
  input wire fault_report_pkg::ov_cmp_t ov_cmp_pin,
  input wire logic angle_update,
  input wire logic pwm_cycle_start,
  input wire logic serial_msg_start,
  input wire logic err_read,
  input wire logic lbist_start_wr,
  input wire logic unlocked,
  input wire logic [31:0] lbist_sig_in,
  input wire logic frame_req,
  input wire logic frame_ready,
  output logic frame_taken,
  output logic frame_valid,
  output fault_report_pkg::frame_t frame_data,
  output fault_report_pkg::drive_t drive,
  output logic pwm_half_freq,
  output logic [6:0] pwm_duty,
  output logic sent_reset,
  output logic [`ERR_W-1:0] serial_flags,
  output logic [`ERR_W-1:0] err_rd_data,
  output logic comm_block,
  output logic lbist_done,
  output logic lbist_pass,
  output logic [31:0] lbist_signature
);
  typedef struct packed {
    fault_report_pkg::ov_cmp_t ov_s1;
    fault_report_pkg::ov_cmp_t ov_s2;
    logic ov;
    logic [`ERR_W-1:0] err;
    logic [`ERR_W-1:0] serial;
    logic [7:0] diag;
    logic [`ERR_W-1:0] serial_out;
    logic [`ERR_W-1:0] rd_data;
    logic pwm_half;
    logic [6:0] duty;
    fault_report_pkg::drive_t drv;
    logic [`HOLD_W-1:0] hold_cnt;
    logic sent_rst;
    logic taken;
    logic lb_run;
    logic [`LBIST_CNT_W-1:0] lb_cnt;
    logic lb_done;
    logic lb_pass;
    logic [31:0] lb_sig;
  } state_t;
  localparam state_t STATE_RESET = '{
    ov_s1: '0, ov_s2: '0, ov: 1'b0,
    err: `ERR_RESET, serial: `ERR_RESET, diag: `DIAG_RESET,
    serial_out: '0, rd_data: '0, pwm_half: 1'b0, duty: `DUTY_NONE,
    drv: fault_report_pkg::DRV_HIZ, hold_cnt: '0, sent_rst: 1'b0, taken: 1'b0,
    lb_run: 1'b0, lb_cnt: '0, lb_done: 1'b0, lb_pass: 1'b0, lb_sig: '0
  };
  state_t s_reg;
  state_t s_next;
  fault_report_pkg::frame_t frame_word;
  logic fifo_in_ready;
  logic frame_push;
  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [1:0] status_of(input logic [`ERR_W-1:0] e);
    logic [1:0] st;
    st[0] = e[`ERR_SLF] | e[`ERR_SRR] | e[`ERR_ACF] | e[`ERR_TSE] | e[`ERR_POR];
    st[1] = e[`ERR_UVD] | e[`ERR_OVD] | e[`ERR_SAT] | e[`ERR_AOC];
    return st;
  endfunction
  function automatic logic [7:0] diag_of(input logic [`ERR_W-1:0] e);
    logic [7:0] d;
    d[`DIAG_SLF] = e[`ERR_SLF];
    d[`DIAG_SRR] = e[`ERR_SRR];
    d[`DIAG_ACF] = e[`ERR_ACF];
    d[`DIAG_TSE] = e[`ERR_TSE];
    d[`DIAG_POR] = e[`ERR_POR];
    d[`DIAG_UOV] = e[`ERR_UVD] | e[`ERR_OVD];
    d[`DIAG_SAT] = e[`ERR_SAT];
    d[`DIAG_AOC] = e[`ERR_AOC];
    return d;
  endfunction
  // Returns {found, index} of the highest priority coded PWM fault
  function automatic logic [4:0] top_fault(input logic [`ERR_W-1:0] e);
    logic [4:0] r;
    r = '0;
    if (e[`ERR_SLF]) r = {1'b1, 4'(`ERR_SLF)};
    else if (e[`ERR_SRR]) r = {1'b1, 4'(`ERR_SRR)};
    else if (e[`ERR_ACF]) r = {1'b1, 4'(`ERR_ACF)};
    else if (e[`ERR_TSE]) r = {1'b1, 4'(`ERR_TSE)};
    else if (e[`ERR_POR]) r = {1'b1, 4'(`ERR_POR)};
    else if (e[`ERR_UVD]) r = {1'b1, 4'(`ERR_UVD)};
    else if (e[`ERR_OVD]) r = {1'b1, 4'(`ERR_OVD)};
    else if (e[`ERR_SAT]) r = {1'b1, 4'(`ERR_SAT)};
    else if (e[`ERR_AOC]) r = {1'b1, 4'(`ERR_AOC)};
    return r;
  endfunction
  function automatic logic [6:0] duty_of(input logic [3:0] idx);
    logic [6:0] d;
    case (idx)
      4'(`ERR_SLF): d = `DUTY_SLF;
      4'(`ERR_SRR): d = `DUTY_SRR;
      4'(`ERR_ACF): d = `DUTY_ACF;
      4'(`ERR_TSE): d = `DUTY_TSE;
      4'(`ERR_POR): d = `DUTY_POR;
      4'(`ERR_UVD): d = `DUTY_UVD;
      4'(`ERR_OVD): d = `DUTY_OVD;
      4'(`ERR_SAT): d = `DUTY_SAT;
      4'(`ERR_AOC): d = `DUTY_AOC;
      default: d = `DUTY_NONE;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Frames are refused while the FIFO is full, so no flag is cleared for
  // a frame that never left
  assign frame_push = frame_req & fifo_in_ready & ~s_reg.lb_run;
  always_comb begin
    frame_word.frame_status_bits = status_of(s_reg.err);
    frame_word.diag_valid = (cfg.sent_data_sel == `SENT_DIAG_OPT_A) |
                            (cfg.sent_data_sel == `SENT_DIAG_OPT_B) |
                            (cfg.sent_data_sel == `SENT_DIAG_OPT_C);
    frame_word.diag_byte = frame_word.diag_valid ? s_reg.diag : 8'h00;
  end
  frame_fifo #(
    .WIDTH($bits(fault_report_pkg::frame_t)),
    .DEPTH(`FRAME_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(frame_push),
    .in_ready(fifo_in_ready),
    .in_data(frame_word),
    .out_valid(frame_valid),
    .out_ready(frame_ready),
    .out_data(frame_data)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic rise, fall, acc, crit;
    logic [`ERR_W-1:0] live, clr;
    logic [4:0] top;
    fault_report_pkg::drive_t drv;
    rise = 1'b0;
    fall = 1'b0;
    acc = 1'b0;
    crit = 1'b0;
    live = '0;
    clr = '0;
    top = '0;
    drv = fault_report_pkg::DRV_NORMAL;
    s_next = s_reg;
    s_next.ov_s1 = ov_cmp_pin;
    s_next.ov_s2 = s_reg.ov_s1;
    // Hysteresis: set above the rise level, clear below the fall level
    if (cfg.ovd_sel == `OVD_SEL_HIGH) begin
      rise = s_reg.ov_s2.hi_rise;
      fall = s_reg.ov_s2.hi_fall;
    end else begin
      rise = s_reg.ov_s2.lo_rise;
      fall = s_reg.ov_s2.lo_fall;
    end
    if (rise) begin
      s_next.ov = 1'b1;
    end else if (fall) begin
      s_next.ov = 1'b0;
    end
    live = faults_live;
    live[`ERR_OVD] = cfg.lock_set & s_reg.ov;
    acc = ~s_reg.lb_run;
    if (frame_push && cfg.out_mode == fault_report_pkg::MODE_SENT) begin
      if (frame_word.frame_status_bits != 2'b00) begin
        clr = clr | s_reg.err;
      end
    end
    if (err_read && acc) begin
      s_next.rd_data = s_reg.err;
      clr = clr | s_reg.err;
    end
    if (pwm_cycle_start && cfg.out_mode == fault_report_pkg::MODE_PWM) begin
      top = top_fault(s_reg.err);
      s_next.pwm_half = top[4];
      s_next.duty = top[4] ? duty_of(top[3:0]) : `DUTY_NONE;
      if (top[4]) begin
        clr[top[3:0]] = 1'b1;
      end
    end
    // Analog reports directly, so a clearable flag lasts only as long as its cause
    if (cfg.out_mode == fault_report_pkg::MODE_ANALOG) begin
      clr = clr | ~live;
    end
    // Set wins over clear; critical flags never clear here
    s_next.err = (s_reg.err & ~(clr & `ERR_CLEARABLE_MASK)) | live;
    if (serial_msg_start) begin
      s_next.serial_out = s_reg.serial;
      s_next.serial = live;
    end else begin
      s_next.serial = s_reg.serial | live;
    end
    if (frame_push && frame_word.diag_valid) begin
      s_next.diag = diag_of(live);
    end else begin
      s_next.diag = s_reg.diag | diag_of(live);
    end
    crit = |(s_reg.err & `ERR_CRIT_MASK);
    s_next.sent_rst = 1'b0;
    if (s_reg.hold_cnt != '0 && angle_update) begin
      s_next.hold_cnt = s_reg.hold_cnt - 1'b1;
    end
    if (!cfg.lock_set && s_reg.ov) begin
      drv = fault_report_pkg::DRV_HIZ;
    end else if (crit) begin
      drv = (cfg.out_mode == fault_report_pkg::MODE_ANALOG) ?
            fault_report_pkg::DRV_HIGH : fault_report_pkg::DRV_HIZ;
    end else if (cfg.out_mode == fault_report_pkg::MODE_ANALOG) begin
      if (|(s_reg.err & `ERR_ANALOG_MASK)) begin
        drv = cfg.fault_level;
        if (cfg.fault_level == fault_report_pkg::DRV_HIZ) begin
          s_next.hold_cnt = cfg.hiz_hold;
        end
      end else if (s_reg.hold_cnt != '0) begin
        // Gives the load time to pull the pin to its rail
        drv = fault_report_pkg::DRV_HIZ;
      end
    end else if (live[`ERR_UVD]) begin
      drv = cfg.fault_level;
      s_next.sent_rst = (cfg.out_mode == fault_report_pkg::MODE_SENT);
    end else if (cfg.dig_resp_sel && |live) begin
      drv = fault_report_pkg::DRV_HIZ;
    end
    s_next.drv = drv;
    s_next.taken = frame_push;
    if (s_reg.lb_run) begin
      s_next.lb_cnt = s_reg.lb_cnt + 1'b1;
      if (s_reg.lb_cnt == `LBIST_CNT_W'(LBIST_CYCLES - 1)) begin
        s_next.lb_run = 1'b0;
        s_next.lb_done = 1'b1;
        s_next.lb_sig = lbist_sig_in;
        s_next.lb_pass = (lbist_sig_in == `LBIST_GOOD_SIG);
      end
    end else if (lbist_start_wr && unlocked) begin
      s_next.lb_run = 1'b1;
      s_next.lb_cnt = '0;
      s_next.lb_done = 1'b0;
      s_next.lb_pass = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign frame_taken = s_reg.taken;
  assign drive = s_reg.drv;
  assign pwm_half_freq = s_reg.pwm_half;
  assign pwm_duty = s_reg.duty;
  assign sent_reset = s_reg.sent_rst;
  assign serial_flags = s_reg.serial_out;
  assign err_rd_data = s_reg.rd_data;
  assign comm_block = s_reg.lb_run;
  assign lbist_done = s_reg.lb_done;
  assign lbist_pass = s_reg.lb_pass;
  assign lbist_signature = s_reg.lb_sig;
endmodule

`default_nettype wire

//--- rtl/fault_report_pkg.sv
/*
  Types shared by the fault reporting logic: output modes, pin drive
  responses, configuration bundle, overvoltage comparator bundle and the
  per-frame SENT fault word.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fault_report_pkg;

  typedef enum logic [1:0] {
    MODE_ANALOG,
    MODE_PWM,
    MODE_SENT
  } out_mode_t;

  typedef enum logic [1:0] {
    DRV_NORMAL,
    DRV_HIZ,
    DRV_HIGH,
    DRV_LOW
  } drive_t;

  typedef struct packed {
    out_mode_t out_mode;
    logic lock_set;
    logic ovd_sel;
    logic dig_resp_sel;
    drive_t fault_level;
    logic [3:0] hiz_hold;
    logic [3:0] sent_data_sel;
  } cfg_t;

  // Rise: supply above rise threshold; fall: supply below fall threshold
  typedef struct packed {
    logic hi_rise;
    logic hi_fall;
    logic lo_rise;
    logic lo_fall;
  } ov_cmp_t;

  typedef struct packed {
    logic [1:0] frame_status_bits;
    logic diag_valid;
    logic [7:0] diag_byte;
  } frame_t;

endpackage

//--- test/fault_report_output_logic_asserts.sv
/* Concurrent checks on the fault reporting ports.
   Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/100ps
`include "fault_report_defs.svh"
`default_nettype none
////////////////////////////////////////
module fro_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire fault_report_pkg::cfg_t cfg,
  input wire logic [`ERR_W-1:0] faults_live,
  input wire logic pwm_cycle_start,
  input wire logic err_read,
  input wire logic lbist_start_wr,
  input wire logic unlocked,
  input wire logic frame_taken,
  input wire fault_report_pkg::drive_t drive,
  input wire logic pwm_half_freq,
  input wire logic [6:0] pwm_duty,
  input wire logic sent_reset,
  input wire logic [`ERR_W-1:0] err_rd_data,
  input wire logic comm_block,
  input wire logic lbist_done,
  input wire logic lbist_pass,
  input wire logic [31:0] lbist_signature
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic pwm_m, ana_m, crit;
  assign pwm_m = cfg.out_mode == fault_report_pkg::MODE_PWM;
  assign ana_m = cfg.out_mode == fault_report_pkg::MODE_ANALOG;
  assign crit = |faults_live[`ERR_OFE:`ERR_EUE];
  // Two edges of a live flag so the register has surely caught it
  sequence slf_held;
    faults_live[`ERR_SLF] ##1 faults_live[`ERR_SLF];
  endsequence
  sequence bist_end;
    comm_block ##1 !comm_block;
  endsequence
  bist_start_a: assert property (lbist_start_wr && unlocked && !comm_block |=> comm_block)
    else $error("self-test did not start");
  bist_done_a: assert property (bist_end |-> ##[0:1] (lbist_done &&
    lbist_pass == (lbist_signature == `LBIST_GOOD_SIG))) else $error("self-test result wrong");
  no_frame_a: assert property (comm_block |=> !frame_taken)
    else $error("frame taken during self-test");
  pwm_slf_a: assert property (slf_held ##0 (pwm_cycle_start && pwm_m && !crit)
    |=> pwm_half_freq && pwm_duty == `DUTY_SLF) else $error("pwm code wrong");
  // A critical flag reaches the register one edge before the drive follows it
  crit_ana_a: assert property (crit && ana_m ##1 ana_m && cfg.lock_set
    |=> drive == fault_report_pkg::DRV_HIGH) else $error("analog critical not high");
  crit_dig_a: assert property (crit ##1 !ana_m |=> drive == fault_report_pkg::DRV_HIZ)
    else $error("digital critical not released");
  uvd_sent_a: assert property (faults_live[`ERR_UVD] &&
    cfg.out_mode == fault_report_pkg::MODE_SENT |=> sent_reset) else $error("no engine reset");
  // Undervoltage keeps its configured level even with the select set
  resp_sel_a: assert property (cfg.dig_resp_sel && pwm_m && |faults_live &&
    !faults_live[`ERR_UVD]
    |=> drive == fault_report_pkg::DRV_HIZ) else $error("response select ignored");
  err_rd_a: assert property (slf_held ##0 (err_read && !comm_block)
    |=> err_rd_data[`ERR_SLF]) else $error("read lost flag");
endmodule
bind fault_report_output_logic fro_asserts fro_asserts_inst (.clk, .rst, .cfg, .faults_live,
  .pwm_cycle_start, .err_read, .lbist_start_wr, .unlocked, .frame_taken, .drive,
  .pwm_half_freq, .pwm_duty, .sent_reset, .err_rd_data, .comm_block, .lbist_done,
  .lbist_pass, .lbist_signature);
`default_nettype wire

//--- test/host_model.sv
/* Host frame sink at the far side of the frame FIFO.
   Assumes the bench drives stall just after a rising edge. */
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////
module host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic frame_valid,
  input wire fault_report_pkg::frame_t frame_data,
  output logic frame_ready
);
  fault_report_pkg::frame_t rx[$];
  int untrusted = 0;
  // Stall models a receiver still busy, so the FIFO can fill
  assign frame_ready = !stall;
  always @(posedge clk) begin
    if (!rst && frame_valid && frame_ready) begin
      rx.push_back(frame_data);
      if (frame_data.frame_status_bits != 2'h0) untrusted++;
    end
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
/* Self-checking bench for the fault reporting logic.
   Assumes the checker and host model are compiled before it. */
`timescale 1ns/100ps
`include "fault_report_defs.svh"
`default_nettype none
////////////////////////////////////////
module testbench;
  logic clk = 0;
  logic rst = 1;
  fault_report_pkg::cfg_t cfg = '0;
  logic [`ERR_W-1:0] faults_live = '0;
  fault_report_pkg::ov_cmp_t ov_cmp_pin = 4'h5;
  logic angle_update = 0, pwm_cycle_start = 0, serial_msg_start = 0, err_read = 0;
  logic lbist_start_wr = 0, unlocked = 0, frame_req = 0, stall = 1;
  logic [31:0] lbist_sig_in = `LBIST_GOOD_SIG;
  logic frame_ready, frame_taken, frame_valid, pwm_half_freq, sent_reset, comm_block;
  logic lbist_done, lbist_pass;
  fault_report_pkg::frame_t frame_data;
  fault_report_pkg::drive_t drive;
  logic [6:0] pwm_duty;
  logic [`ERR_W-1:0] serial_flags, err_rd_data, e;
  logic [31:0] lbist_signature;
  int n_errors = 0, tests_run = 0, cycles = 0, k, got;
  typedef struct {logic [12:0] f; logic [3:0] ov; logic sel; logic [6:0] duty;} row_t;
  row_t rows[14] = '{'{13'h000, 4'h5, 1'h0, `DUTY_POR}, '{13'h010, 4'h5, 1'h0, `DUTY_SLF},
    '{13'h020, 4'h5, 1'h0, `DUTY_SRR}, '{13'h001, 4'h5, 1'h0, `DUTY_ACF},
    '{13'h004, 4'h5, 1'h0, `DUTY_TSE}, '{13'h100, 4'h5, 1'h0, `DUTY_UVD},
    '{13'h008, 4'h5, 1'h0, `DUTY_SAT}, '{13'h002, 4'h5, 1'h0, `DUTY_AOC},
    '{13'h018, 4'h5, 1'h0, `DUTY_SLF}, '{13'h104, 4'h5, 1'h0, `DUTY_TSE},
    '{13'h000, 4'hA, 1'h0, `DUTY_OVD}, '{13'h000, 4'h6, 1'h0, `DUTY_NONE},
    '{13'h000, 4'h6, 1'h1, `DUTY_OVD}, '{13'h000, 4'h5, 1'h0, `DUTY_NONE}};
  logic [10:0] ef[5] = '{11'h1FF, 11'h100, 11'h308, 11'h100, 11'h540};
  fault_report_output_logic #(.LBIST_CYCLES(20)) fault_report_output_logic_inst (
    .clk, .rst, .cfg, .faults_live, .ov_cmp_pin, .angle_update, .pwm_cycle_start,
    .serial_msg_start, .err_read, .lbist_start_wr, .unlocked, .lbist_sig_in, .frame_req,
    .frame_ready, .frame_taken, .frame_valid, .frame_data, .drive, .pwm_half_freq,
    .pwm_duty, .sent_reset, .serial_flags, .err_rd_data, .comm_block, .lbist_done,
    .lbist_pass, .lbist_signature);
  host_model host_model_inst (.clk, .rst, .stall, .frame_valid, .frame_data, .frame_ready);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ends with an idle edge so back-to-back pulses never collide
  task automatic pulse(ref logic s);
    s = 1;
    tick();
    s = 0;
    tick();
  endtask
  task automatic push1();
    got = 0;
    frame_req = 1;
    tick();
    frame_req = 0;
    repeat (2) begin
      got |= frame_taken;
      tick();
    end
    check("frame_taken", got, 1);
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cfg.lock_set = 1;
    cfg.out_mode = fault_report_pkg::MODE_PWM;
    tick(5);
    check("drive", drive, fault_report_pkg::DRV_HIZ);
    check("frame_valid", frame_valid, 0);
    tick();
    rst = 0;
    tick();
    pulse(angle_update);
    foreach (rows[i]) begin
      faults_live = rows[i].f;
      ov_cmp_pin = rows[i].ov;
      cfg.ovd_sel = rows[i].sel;
      tick(4);
      pulse(pwm_cycle_start);
      check("pwm_duty", pwm_duty, rows[i].duty);
      check("pwm_half", pwm_half_freq, rows[i].duty != `DUTY_NONE);
      e = rows[i].f | (rows[i].duty == `DUTY_OVD ? 13'h0200 : 13'h0000);
      for (k = 0; k < 2; k++) begin
        pulse(err_read);
        check("err_rd", err_rd_data, e);
        faults_live = '0;
        ov_cmp_pin = 4'h5;
        tick(4);
      end
    end
    pulse(serial_msg_start);
    check("serial", serial_flags, 13'h037F);
    pulse(serial_msg_start);
    check("serial", serial_flags, 13'h0000);
    cfg.out_mode = fault_report_pkg::MODE_SENT;
    cfg.sent_data_sel = 4'h2;
    push1();
    cfg.sent_data_sel = 4'h8;
    push1();
    cfg.sent_data_sel = 4'hD;
    for (k = 0; k < 2; k++) begin
      faults_live = k ? 13'h0008 : 13'h0004;
      tick(2);
      faults_live = '0;
      tick();
      push1();
      if (k == 0) push1();
    end
    cfg.sent_data_sel = 4'h0;
    got = 0;
    frame_req = 1;
    for (k = 0; k < 14; k++) begin
      if (k == 12) frame_req = 0;
      got += frame_taken;
      tick();
    end
    check("fifo_fill", got, 3);
    stall = 0;
    tick(12);
    check("rx_count", host_model_inst.rx.size(), 8);
    check("untrusted", host_model_inst.untrusted, 2);
    check("frame_valid", frame_valid, 0);
    for (k = 0; k < 8; k++) begin
      if (k < 5) check("frame", host_model_inst.rx[k], ef[k]);
      else check("diag_valid", host_model_inst.rx[k].diag_valid, 0);
    end
    cfg.fault_level = fault_report_pkg::DRV_HIGH;
    faults_live = 13'h0100;
    tick(2);
    check("drive", drive, fault_report_pkg::DRV_HIGH);
    check("sent_reset", sent_reset, 1);
    cfg.out_mode = fault_report_pkg::MODE_PWM;
    cfg.dig_resp_sel = 1;
    faults_live = 13'h0010;
    tick(2);
    check("drive", drive, fault_report_pkg::DRV_HIZ);
    faults_live = '0;
    tick(2);
    check("drive", drive, fault_report_pkg::DRV_NORMAL);
    pulse(err_read);
    cfg.dig_resp_sel = 0;
    cfg.out_mode = fault_report_pkg::MODE_ANALOG;
    cfg.fault_level = fault_report_pkg::DRV_HIZ;
    cfg.hiz_hold = 4'h2;
    faults_live = 13'h0020;
    tick();
    faults_live = '0;
    pulse(angle_update);
    check("drive", drive, fault_report_pkg::DRV_HIZ);
    pulse(angle_update);
    pulse(angle_update);
    check("drive", drive, fault_report_pkg::DRV_NORMAL);
    cfg.fault_level = fault_report_pkg::DRV_LOW;
    cfg.lock_set = 0;
    ov_cmp_pin = 4'hA;
    tick(4);
    check("drive", drive, fault_report_pkg::DRV_HIZ);
    ov_cmp_pin = 4'h5;
    cfg.lock_set = 1;
    faults_live = 13'h0010;
    tick(4);
    check("drive", drive, fault_report_pkg::DRV_LOW);
    pulse(lbist_start_wr);
    check("comm_block", comm_block, 0);
    unlocked = 1;
    pulse(lbist_start_wr);
    check("comm_block", comm_block, 1);
    for (k = 0; k < 2; k++) begin
      frame_req = 1;
      for (got = 0; got < 40 && comm_block; got++) tick();
      frame_req = 0;
      tick();
      check("rx_count", host_model_inst.rx.size(), 8);
      check("done", lbist_done, 1);
      check("pass", lbist_pass, k == 0);
      check("signature", lbist_signature, lbist_sig_in);
      lbist_sig_in = 32'h00000001;
      if (k == 0) pulse(lbist_start_wr);
    end
    faults_live = 13'h1000;
    tick(2);
    check("drive", drive, fault_report_pkg::DRV_HIGH);
    cfg.out_mode = fault_report_pkg::MODE_PWM;
    tick(2);
    check("drive", drive, fault_report_pkg::DRV_HIZ);
    faults_live = 13'h1010;
    tick();
    // SLF stays live and is set again after each report, so the code must not drop between the two cycle starts
    repeat (2) begin
      pulse(pwm_cycle_start);
      check("pwm_half", pwm_half_freq, 1);
      check("pwm_duty", pwm_duty, `DUTY_SLF);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
